//--- rtl/mtp_translation_path.sv
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module mtp_translation_path (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // AHB-Lite register slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic [31:0]                 hrdata,
    output logic                        hresp,
    // Execution unit access port
    input  wire logic                   acc_valid,
    input  wire mtp_pkg::mtp_access_t   acc,
    output logic                        acc_ready,
    output logic                        acc_done,
    output logic [1:0]                  acc_result,
    input  wire logic                   translation_disable_in,
    // Bus controller side
    output logic                        address_strobe,
    output mtp_pkg::mtp_bus_t           bus,
    output logic                        cache_inhibit_output,
    output logic                        translation_abort,
    output logic                        bus_error_exc,
    // Table search sequencer
    output logic                        walk_req_valid,
    output mtp_pkg::mtp_walk_req_t      walk_req,
    input  wire logic                   walk_ack,
    input  wire mtp_pkg::mtp_la_data_t  walk_rsp
);
    import mtp_pkg::*;

    mtp_state_t    state_q, state_d;
    logic [31:0]   tc_q;
    logic [31:0]   tw0_q;
    logic [31:0]   tw1_q;

    logic [15:0]   misses_q;
    logic [1:0]    last_res_q;

    mtp_access_t   acc_q;
    logic          dis_q;
    logic [31:2]   hold_hi_q;
    logic          hold_ci_q;
    logic          flush_q;

    logic          hreadyout_q, hresp_q;
    logic [31:0]   hrdata_q;
    logic          wr_pend_q;
    logic [7:0]    wr_addr_q;

    logic          acc_ready_q, acc_done_q, as_q, ci_out_q, abort_q, berr_q;
    logic [1:0]    acc_result_q;
    mtp_bus_t      bus_q;

    logic          walk_valid_q;
    mtp_walk_req_t walk_req_q;

    // Bus slave decode
    logic          ahb_take;
    logic [7:0]    rd_ofs;
    logic [31:0]   rd_word;
    logic [31:0]   status_word;
    logic          wr_tc, wr_tw0, wr_tw1, wr_flush;

    assign ahb_take    = hsel & htrans[1] & hready;
    assign rd_ofs      = haddr[7:0];
    assign status_word = {25'h0, dis_q, walk_valid_q, state_q, last_res_q};
    assign rd_word     = (rd_ofs == MTP_REG_TC)     ? tc_q :
                         (rd_ofs == MTP_REG_TW0)    ? tw0_q :
                         (rd_ofs == MTP_REG_TW1)    ? tw1_q :
                         (rd_ofs == MTP_REG_STATUS) ? status_word :
                         (rd_ofs == MTP_REG_MISSES) ? {16'h0, misses_q} : 32'h0;

    assign wr_tc       = wr_pend_q & (wr_addr_q == MTP_REG_TC);
    assign wr_tw0      = wr_pend_q & (wr_addr_q == MTP_REG_TW0);
    assign wr_tw1      = wr_pend_q & (wr_addr_q == MTP_REG_TW1);
    assign wr_flush    = wr_pend_q & (wr_addr_q == MTP_REG_FLUSH) & hwdata[MTP_FLUSH_ALL];

    // Address phase capture, zero wait state, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q   <= 1'b0;
            wr_addr_q   <= 8'h00;
            hrdata_q    <= MTP_RST_VAL;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else begin
            wr_pend_q   <= ahb_take & hwrite;
            wr_addr_q   <= ahb_take ? haddr[7:0] : wr_addr_q;
            hrdata_q    <= (ahb_take & ~hwrite) ? rd_word : 32'h0;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
    end

    // Control and window registers; reset drops every enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tc_q    <= MTP_RST_VAL;
            tw0_q   <= MTP_RST_VAL;
            tw1_q   <= MTP_RST_VAL;
            flush_q <= 1'b0;
        end else begin
            tc_q    <= wr_tc  ? hwdata : tc_q;
            tw0_q   <= wr_tw0 ? hwdata : tw0_q;
            tw1_q   <= wr_tw1 ? hwdata : tw1_q;
            flush_q <= wr_flush;
        end
    end

    // Transparent windows
    logic w0_hit, w0_ci, w1_hit, w1_ci;

    mtp_window_match u_win0 (
        .win   (tw0_q),
        .fc    (acc_q.fc),
        .a_hi  (acc_q.laddr[31 -: MTP_WIN_HI_W]),
        .read  (acc_q.read),
        .rmw   (acc_q.rmw),
        .match (w0_hit),
        .ci    (w0_ci)
    );

    mtp_window_match u_win1 (
        .win   (tw1_q),
        .fc    (acc_q.fc),
        .a_hi  (acc_q.laddr[31 -: MTP_WIN_HI_W]),
        .read  (acc_q.read),
        .rmw   (acc_q.rmw),
        .match (w1_hit),
        .ci    (w1_ci)
    );

    // Lookaside array
    logic         la_hit;
    mtp_la_data_t la_data;
    logic         fill_en;

    assign fill_en = (state_q == MTP_ST_WALK) & walk_valid_q & walk_ack;

    mtp_lookaside u_la (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .flush     (flush_q),
        .lk_fc     (acc_q.fc),
        .lk_la     (acc_q.laddr[31 -: MTP_TAG_W]),
        .hit       (la_hit),
        .hit_data  (la_data),
        .fill_en   (fill_en),
        .fill_data (walk_rsp)
    );

    // Decision for the held access, in documented priority
    logic cpu_space, cache_done, win_hit, xlate_on, is_write;
    logic go_bus, go_fault, go_walk, need_mod;
    logic [31:0] phys;
    logic        phys_ci;

    assign cpu_space  = (acc_q.fc == MTP_CPU_FC);
    assign cache_done = ~cpu_space & acc_q.read & ~acc_q.rmw & acc_q.cache_hit;
    assign win_hit    = w0_hit | w1_hit;
    assign xlate_on   = tc_q[MTP_TC_EN] & ~dis_q;
    // Locked cycles count as writes
    assign is_write   = ~acc_q.read | acc_q.rmw;
    assign need_mod   = is_write & ~la_data.mod;

    // Window and bypass paths never consult write protection
    assign go_fault   = ~acc_q.cont & ~cpu_space & ~cache_done & ~win_hit & xlate_on & la_hit
                      & (la_data.berr | (is_write & la_data.wp));
    assign go_walk    = ~acc_q.cont & ~cpu_space & ~cache_done & ~win_hit & xlate_on
                      & (~la_hit | (~go_fault & need_mod));
    assign go_bus     = ~cache_done & ~go_fault & ~go_walk;

    // Physical address: held base for continuation cycles, else by path
    assign phys = acc_q.cont ? {hold_hi_q, acc_q.laddr[1:0]} :
                  (cpu_space | win_hit | ~xlate_on) ? acc_q.laddr :
                  {la_data.pa, acc_q.laddr[MTP_OFS_W-1:0]};
    assign phys_ci = acc_q.cont ? hold_ci_q :
                     cpu_space ? 1'b0 :
                     win_hit ? (w0_ci | w1_ci) :
                     (xlate_on & la_data.ci);

    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            MTP_ST_IDLE: begin
                if (acc_valid) begin
                    state_d = MTP_ST_DECIDE;
                end
            end

            MTP_ST_DECIDE: begin
                if (go_walk) begin
                    state_d = MTP_ST_WALK;
                end else begin
                    state_d = MTP_ST_IDLE;
                end
            end

            MTP_ST_WALK: begin
                if (walk_ack) begin
                    state_d = MTP_ST_DECIDE;
                end
            end

            default: begin
                state_d = MTP_ST_IDLE;
            end
        endcase
    end

    // State, access capture and held first-cycle translation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= MTP_ST_IDLE;
            acc_q     <= '0;
            dis_q     <= 1'b0;
            hold_hi_q <= '0;
            hold_ci_q <= 1'b0;
        end else begin
            state_q <= state_d;

            if (state_q == MTP_ST_IDLE && acc_valid) begin
                acc_q <= acc;
                // Disable only takes effect at a new operand's first cycle
                dis_q <= acc.cont ? dis_q : translation_disable_in;
            end

            // Continuation cycles reuse this base
            if (state_q == MTP_ST_DECIDE && go_bus) begin
                hold_hi_q <= phys[31:2];
                hold_ci_q <= phys_ci;
            end
        end
    end

    // Access port and bus controller outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_ready_q  <= 1'b0;
            acc_done_q   <= 1'b0;
            acc_result_q <= MTP_RES_BUS;
            last_res_q   <= MTP_RES_BUS;
            as_q         <= 1'b0;
            bus_q        <= '0;
            ci_out_q     <= 1'b0;
            abort_q      <= 1'b0;
            berr_q       <= 1'b0;
        end else begin
            acc_ready_q <= (state_q == MTP_ST_IDLE) & acc_valid;
            acc_done_q  <= (state_q == MTP_ST_DECIDE) & ~go_walk;
            // Strobe only for a cleared decision, so aborts never reach the bus
            as_q        <= (state_q == MTP_ST_DECIDE) & go_bus;
            abort_q     <= (state_q == MTP_ST_DECIDE) & (go_walk | go_fault);
            berr_q      <= (state_q == MTP_ST_DECIDE) & go_fault;

            if (state_q == MTP_ST_DECIDE && !go_walk) begin
                acc_result_q <= go_fault ? MTP_RES_FAULT :
                                cache_done ? MTP_RES_CACHE : MTP_RES_BUS;
                last_res_q   <= go_fault ? MTP_RES_FAULT :
                                cache_done ? MTP_RES_CACHE : MTP_RES_BUS;
            end

            // Bus fields change only on issue
            if (state_q == MTP_ST_DECIDE && go_bus) begin
                bus_q    <= '{paddr: phys, read: acc_q.read, ci: phys_ci};
                ci_out_q <= phys_ci;
            end
        end
    end

    // Table search handshake and miss counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            walk_valid_q <= 1'b0;
            walk_req_q   <= '0;
            misses_q     <= 16'h0000;
        end else begin
            if (state_q == MTP_ST_DECIDE && go_walk) begin
                walk_valid_q <= 1'b1;
                walk_req_q   <= '{fc: acc_q.fc, laddr: acc_q.laddr,
                                  set_mod: la_hit & need_mod};
                misses_q     <= misses_q + 16'h0001;
            end else if (walk_ack) begin
                walk_valid_q <= 1'b0;
            end
        end
    end

    // Register bus
    assign hreadyout            = hreadyout_q;
    assign hrdata               = hrdata_q;
    assign hresp                = hresp_q;

    // Access port
    assign acc_ready            = acc_ready_q;
    assign acc_done             = acc_done_q;
    assign acc_result           = acc_result_q;

    // Bus controller
    assign address_strobe       = as_q;
    assign bus                  = bus_q;
    assign cache_inhibit_output = ci_out_q;
    assign translation_abort    = abort_q;
    assign bus_error_exc        = berr_q;

    // Table search
    assign walk_req_valid       = walk_valid_q;
    assign walk_req             = walk_req_q;
endmodule
`default_nettype wire

//--- include/mtp_pkg.sv
package mtp_pkg;

    // Access and lookaside geometry
    localparam int          MTP_LA_ENTRIES = 22;
    localparam int          MTP_LA_IDX_W   = 5;
    localparam int          MTP_TAG_W      = 24;
    localparam int          MTP_OFS_W      = 8;
    localparam int          MTP_WIN_HI_W   = 8;
    localparam logic [2:0]  MTP_CPU_FC     = 3'h7;

    // Register byte offsets
    localparam logic [7:0]  MTP_REG_TC     = 8'h00;
    localparam logic [7:0]  MTP_REG_TW0    = 8'h04;
    localparam logic [7:0]  MTP_REG_TW1    = 8'h08;
    localparam logic [7:0]  MTP_REG_FLUSH  = 8'h0c;
    localparam logic [7:0]  MTP_REG_STATUS = 8'h10;
    localparam logic [7:0]  MTP_REG_MISSES = 8'h14;
    localparam logic [31:0] MTP_RST_VAL    = 32'h0000_0000;

    // Field positions
    localparam int          MTP_TC_EN      = 31;
    localparam int          MTP_FLUSH_ALL  = 0;
    localparam int          MTP_W_BASE     = 24;
    localparam int          MTP_W_MASK     = 16;
    localparam int          MTP_W_EN       = 15;
    localparam int          MTP_W_CI       = 10;
    localparam int          MTP_W_RWSEL    = 9;
    localparam int          MTP_W_RWM      = 8;
    localparam int          MTP_W_FCB      = 4;
    localparam int          MTP_W_FCM      = 0;

    // Outcome codes of an access
    localparam logic [1:0]  MTP_RES_BUS    = 2'h0;
    localparam logic [1:0]  MTP_RES_CACHE  = 2'h1;
    localparam logic [1:0]  MTP_RES_FAULT  = 2'h2;

    typedef struct packed {
        logic [2:0]  fc;
        logic [31:0] laddr;
        logic        read;
        logic        rmw;
        logic        cont;
        logic        cache_hit;
    } mtp_access_t;

    typedef struct packed {
        logic                 berr;
        logic                 ci;
        logic                 wp;
        logic                 mod;
        logic [MTP_TAG_W-1:0] pa;
    } mtp_la_data_t;

    typedef struct packed {
        logic [2:0]  fc;
        logic [31:0] laddr;
        logic        set_mod;
    } mtp_walk_req_t;

    typedef struct packed {
        logic [31:0] paddr;
        logic        read;
        logic        ci;
    } mtp_bus_t;

    typedef enum logic [2:0] {
        MTP_ST_IDLE   = 3'b001,
        MTP_ST_DECIDE = 3'b010,
        MTP_ST_WALK   = 3'b100
    } mtp_state_t;

endpackage

//--- rtl/mtp_window_match.sv
`timescale 1ns/10ps
`default_nettype none
module mtp_window_match (
    input  wire logic [31:0]                  win,
    input  wire logic [2:0]                   fc,
    input  wire logic [mtp_pkg::MTP_WIN_HI_W-1:0] a_hi,
    input  wire logic                         read,
    input  wire logic                         rmw,
    output logic                              match,
    output logic                              ci
);
    import mtp_pkg::*;

    logic [2:0]              fc_diff;
    logic [MTP_WIN_HI_W-1:0] a_diff;
    logic                    rw_ok;

    // Masked compares of function code and top address bits
    assign fc_diff = (fc ^ win[MTP_W_FCB +: 3]) & ~win[MTP_W_FCM +: 3];
    assign a_diff  = (a_hi ^ win[MTP_W_BASE +: MTP_WIN_HI_W])
                   & ~win[MTP_W_MASK +: MTP_WIN_HI_W];
    // Direction check; locked cycles need the direction mask
    assign rw_ok   = win[MTP_W_RWM] | (~rmw & (read == win[MTP_W_RWSEL]));
    assign match   = win[MTP_W_EN] & (fc_diff == 3'h0) & (a_diff == '0) & rw_ok;
    assign ci      = match & win[MTP_W_CI];
endmodule
`default_nettype wire

//--- rtl/mtp_lookaside.sv
`timescale 1ns/10ps
`default_nettype none
module mtp_lookaside (
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          flush,
    input  wire logic [2:0]                    lk_fc,
    input  wire logic [mtp_pkg::MTP_TAG_W-1:0] lk_la,
    output logic                               hit,
    output mtp_pkg::mtp_la_data_t              hit_data,
    input  wire logic                          fill_en,
    input  wire mtp_pkg::mtp_la_data_t         fill_data
);
    import mtp_pkg::*;

    logic [MTP_LA_ENTRIES-1:0] valid_q;
    logic [2:0]                fc_q   [MTP_LA_ENTRIES];
    logic [MTP_TAG_W-1:0]      la_q   [MTP_LA_ENTRIES];
    mtp_la_data_t              data_q [MTP_LA_ENTRIES];
    logic [MTP_LA_ENTRIES-1:0] hit_vec;
    logic [MTP_LA_IDX_W-1:0]   rr_q;
    logic [MTP_LA_IDX_W-1:0]   victim;

    // Tag compare against every entry
    genvar g;
    generate
        for (g = 0; g < MTP_LA_ENTRIES; g++) begin : g_cmp
            assign hit_vec[g] = valid_q[g] & (fc_q[g] == lk_fc) & (la_q[g] == lk_la);
        end
    endgenerate
    assign hit = |hit_vec;

    // Hit data select and victim choice: same tag, else free, else rotating
    always_comb begin
        hit_data = '0;
        victim   = rr_q;
        for (int i = MTP_LA_ENTRIES - 1; i >= 0; i--) begin
            if (!valid_q[i]) begin
                victim = MTP_LA_IDX_W'(i);
            end
        end
        for (int i = 0; i < MTP_LA_ENTRIES; i++) begin
            if (hit_vec[i]) begin
                hit_data = data_q[i];
                victim   = MTP_LA_IDX_W'(i);
            end
        end
    end

    // Rotating replacement pointer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rr_q <= '0;
        end else if (fill_en) begin
            rr_q <= (rr_q == MTP_LA_IDX_W'(MTP_LA_ENTRIES - 1)) ? '0 : rr_q + 1'b1;
        end
    end

    // Entry storage deliberately outside the reset
    always_ff @(posedge hclk) begin
        if (flush) begin
            valid_q <= '0;
        end
        if (fill_en) begin
            valid_q[victim] <= 1'b1;
            fc_q[victim]    <= lk_fc;
            la_q[victim]    <= lk_la;
            data_q[victim]  <= fill_data;
        end
    end
endmodule
`default_nettype wire

//--- verif/mtp_props.sv
`timescale 1ns/10ps
`default_nettype none
module mtp_props (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire mtp_pkg::mtp_access_t   acc,
    input  wire logic                   acc_ready,
    input  wire logic                   acc_done,
    input  wire logic [1:0]             acc_result,
    input  wire logic                   address_strobe,
    input  wire mtp_pkg::mtp_bus_t      bus,
    input  wire logic                   cache_inhibit_output,
    input  wire logic                   translation_abort,
    input  wire logic                   bus_error_exc,
    input  wire logic                   walk_req_valid,
    input  wire mtp_pkg::mtp_walk_req_t walk_req,
    input  wire logic                   walk_ack
);
    import mtp_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Every taken access is answered on the following cycle
    a_ready_answer: assert property (acc_ready |=> (acc_done || translation_abort))
        else $error("access not answered after ready");
    a_abort_silent: assert property (translation_abort |-> !address_strobe)
        else $error("strobe issued with abort");
    a_fault_reported: assert property (bus_error_exc |-> translation_abort && acc_done
        && acc_result == MTP_RES_FAULT) else $error("bus error without fault result");
    a_miss_walks: assert property (translation_abort && !bus_error_exc |-> walk_req_valid
        && !acc_done) else $error("abort without search request");
    a_walk_held: assert property (walk_req_valid && !walk_ack |=> walk_req_valid
        && $stable(walk_req)) else $error("search request dropped or changed");
    a_strobe_inhibit: assert property (address_strobe |-> acc_done
        && acc_result == MTP_RES_BUS && cache_inhibit_output == bus.ci)
        else $error("strobe inhibit or result wrong");
    a_cpu_bypass: assert property (acc_ready && $past(acc.fc) == MTP_CPU_FC
        && !$past(acc.cont) |=> address_strobe && bus.paddr == $past(acc.laddr, 2))
        else $error("cpu space not passed through");
    a_walk_retry: assert property (walk_req_valid && walk_ack |-> ##2
        (acc_done || translation_abort)) else $error("no retry after search");
    a_cache_quiet: assert property (acc_ready && $past(acc.read) && !$past(acc.rmw)
        && $past(acc.cache_hit) && $past(acc.fc) != MTP_CPU_FC && !$past(acc.cont)
        |=> acc_done && acc_result == MTP_RES_CACHE && !address_strobe)
        else $error("cache hit went to bus");
endmodule
bind mtp_translation_path mtp_props i_props (
    .hclk, .hresetn, .acc, .acc_ready, .acc_done, .acc_result, .address_strobe, .bus,
    .cache_inhibit_output, .translation_abort, .bus_error_exc, .walk_req_valid, .walk_req,
    .walk_ack
);
`default_nettype wire

//--- verif/mtp_walk_model.sv
`timescale 1ns/10ps
`default_nettype none
module mtp_walk_model (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   walk_req_valid,
    input  wire mtp_pkg::mtp_walk_req_t walk_req,
    input  wire logic [3:0]             dly,
    input  wire logic [2:0]             flg,
    output logic                        walk_ack,
    output mtp_pkg::mtp_la_data_t       walk_rsp
);
    import mtp_pkg::*;
    logic [3:0]   cnt_q;
    mtp_la_data_t rsp;
    // Frame is the page with four bits flipped; modified follows the request
    assign rsp      = '{flg[2], flg[1], flg[0], walk_req.set_mod,
                        walk_req.laddr[31:8] ^ 24'h0f_0000};
    // Outside the acknowledge cycle the lines carry no stale entry
    assign walk_rsp = walk_ack ? rsp : ~rsp;
    // Search lasts dly + 1 cycles, then one acknowledge cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q    <= 4'h0;
            walk_ack <= 1'b0;
        end else begin
            walk_ack <= 1'b0;
            cnt_q    <= 4'h0;
            if (walk_req_valid && !walk_ack && cnt_q < dly) begin
                cnt_q <= cnt_q + 4'h1;
            end else if (walk_req_valid && !walk_ack) begin
                walk_ack <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import mtp_pkg::*;
    localparam logic [3:0]  K_RD = 4'h8, K_WR = 4'h0, K_RMW = 4'hc, K_CH = 4'h9, K_CRD = 4'ha;
    localparam logic [31:0] EN = 32'h8000_0000, A = 32'h1234_5678, B = 32'h8512_3400;
    localparam logic [31:0] W = 32'h4012_3456, W2 = 32'h4055_0000, C = 32'h2200_0010;
    logic          hclk, hresetn, hsel, hwrite, hreadyout, hresp, acc_valid, acc_ready;
    logic          acc_done, dis, address_strobe, cache_inhibit_output, translation_abort;
    logic          bus_error_exc, walk_req_valid, walk_ack;
    logic [31:0]   haddr, hwdata, hrdata;
    logic [1:0]    htrans, acc_result;
    logic [2:0]    hsize, m_flg;
    logic [3:0]    m_dly;
    mtp_access_t   acc;
    mtp_bus_t      bus;
    mtp_walk_req_t walk_req;
    mtp_la_data_t  walk_rsp;
    int            fail_count = 0;
    int            checked = 0;
    mtp_translation_path i_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .acc_valid, .acc, .acc_ready,
        .acc_done, .acc_result, .translation_disable_in(dis), .address_strobe, .bus,
        .cache_inhibit_output, .translation_abort, .bus_error_exc, .walk_req_valid,
        .walk_req, .walk_ack, .walk_rsp
    );
    mtp_walk_model i_walk (
        .hclk, .hresetn, .walk_req_valid, .walk_req, .dly(m_dly), .flg(m_flg), .walk_ack,
        .walk_rsp
    );
    // Clock
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic final_report();
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [31:0] xpa(input logic [31:0] la);
        return {la[31:8] ^ 24'h0f_0000, la[7:0]};
    endfunction
    // One single-word transfer; read data taken at the data-phase edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [32:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = {hresp, hrdata};
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [32:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk("register", {7'h00, r}, {8'h00, e});
    endtask
    // One access; collects aborts, errors, the issued address and inhibit
    task automatic run(input logic [2:0] fc, input logic [31:0] la, input logic [3:0] k,
                       input logic [1:0] eab, input logic [1:0] ers,
                       input logic [31:0] epa, input logic eci);
        logic [1:0]  ab;
        logic [31:0] pa;
        logic        ci, rd;
        ab = 2'b00;
        pa = 32'h0;
        {ci, rd} = 2'b00;
        @(posedge hclk);
        acc_valid <= 1'b1;
        acc       <= '{fc, la, k[3], k[2], k[1], k[0]};
        do @(posedge hclk); while (acc_ready !== 1'b1);
        acc_valid <= 1'b0;
        do begin
            @(posedge hclk);
            ab = ab | {translation_abort, bus_error_exc};
            if (address_strobe === 1'b1) begin
                pa = bus.paddr;
                {ci, rd} = {cache_inhibit_output, bus.read};
            end
        end while (acc_done !== 1'b1);
        chk("access", {1'b0, rd, ab, acc_result, pa, ci},
            {1'b0, k[3] & (ers == MTP_RES_BUS), eab, ers, epa, eci});
    endtask
    task automatic s_reset();
        rdc(MTP_REG_TC, 32'h0);
        rdc(MTP_REG_TW0, 32'h0);
        rdc(MTP_REG_TW1, 32'h0);
        rdc(8'h20, 32'h0);
        wr(MTP_REG_FLUSH, 32'h1);
        wr(MTP_REG_TC, EN);
    endtask
    task automatic s_bypass();
        run(3'h7, C, K_WR, 2'b00, MTP_RES_BUS, C, 1'b0);
        run(3'h1, C, K_CH, 2'b00, MTP_RES_CACHE, 32'h0, 1'b0);
    endtask
    task automatic s_walk();
        run(3'h1, A, K_RD, 2'b10, MTP_RES_BUS, xpa(A), 1'b0);
        m_dly <= 4'h6;
        run(3'h1, A + 32'h4, K_RD, 2'b00, MTP_RES_BUS, xpa(A + 32'h4), 1'b0);
        run(3'h2, A, K_RD, 2'b10, MTP_RES_BUS, xpa(A), 1'b0);
        run(3'h1, A, K_WR, 2'b10, MTP_RES_BUS, xpa(A), 1'b0);
        run(3'h1, A, K_WR, 2'b00, MTP_RES_BUS, xpa(A), 1'b0);
    endtask
    task automatic s_fault();
        m_flg <= 3'b011;
        run(3'h3, B, K_RD, 2'b10, MTP_RES_BUS, xpa(B), 1'b1);
        run(3'h3, B, K_WR, 2'b11, MTP_RES_FAULT, 32'h0, 1'b0);
        m_flg <= 3'b100;
        run(3'h1, C, K_RD, 2'b11, MTP_RES_FAULT, 32'h0, 1'b0);
        m_flg <= 3'b000;
    endtask
    task automatic s_window();
        wr(MTP_REG_TW0, 32'h4000_8612);
        wr(MTP_REG_TW1, 32'h80cf_8121);
        run(3'h3, W, K_RD, 2'b00, MTP_RES_BUS, W, 1'b1);
        run(3'h1, W, K_WR, 2'b10, MTP_RES_BUS, xpa(W), 1'b0);
        run(3'h1, W2, K_RMW, 2'b10, MTP_RES_BUS, xpa(W2), 1'b0);
        run(3'h3, B, K_WR, 2'b00, MTP_RES_BUS, B, 1'b0);
        wr(MTP_REG_TW1, 32'h80cf_0121);
        run(3'h3, B, K_WR, 2'b11, MTP_RES_FAULT, 32'h0, 1'b0);
        run(3'h3, W2 + EN, K_RD, 2'b10, MTP_RES_BUS, xpa(W2 + EN), 1'b0);
    endtask
    task automatic s_disable();
        dis <= 1'b1;
        run(3'h1, 32'h6600_1204, K_WR, 2'b00, MTP_RES_BUS, 32'h6600_1204, 1'b0);
        run(3'h3, W, K_RD, 2'b00, MTP_RES_BUS, W, 1'b1);
        dis <= 1'b0;
        run(3'h1, A, K_RD, 2'b00, MTP_RES_BUS, xpa(A), 1'b0);
        dis <= 1'b1;
        run(3'h1, 32'h7777_7779, K_CRD, 2'b00, MTP_RES_BUS, xpa(A) | 32'h1, 1'b0);
        dis <= 1'b0;
    endtask
    task automatic s_rereset();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(MTP_REG_TW0, 32'h0);
        wr(MTP_REG_TC, EN);
        run(3'h1, A, K_RD, 2'b00, MTP_RES_BUS, xpa(A), 1'b0);
    endtask
    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        acc_valid = 1'b0;
        acc = '0;
        dis = 1'b0;
        m_dly = 4'h0;
        m_flg = 3'h0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        s_reset();
        s_bypass();
        s_walk();
        s_fault();
        s_window();
        s_disable();
        s_rereset();
        final_report();
    end
    // Watchdog
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        final_report();
    end
endmodule
`default_nettype wire
